/* verilog/gtc_regs.vh */
`ifndef GTC_REGS_VH
`define GTC_REGS_VH
// ***********************************
// register offsets
// ***********************************
`define GTC_OFF_CNTCTL   8'h00
`define GTC_OFF_SWTRIG   8'h14
`define GTC_OFF_STATUS   8'h10
`define GTC_OFF_MASK     8'h0C
`define GTC_OFF_COUNT    8'h24
`define GTC_OFF_PERIOD   8'h2C
`define GTC_OFF_CMP1     8'h34
`define GTC_OFF_CMP4     8'h40
`define GTC_OFF_DMABURST 8'h48
`define GTC_OFF_DMADATA  8'h4C
// ***********************************
// control field positions
// ***********************************
`define GTC_CNTCTL_MASK  16'h07FF
`define GTC_BIT_PLUS     10
`define GTC_BIT_DIVHI    9
`define GTC_BIT_DIVLO    8
`define GTC_BIT_SHADOW   7
`define GTC_BIT_TWCHI    6
`define GTC_BIT_TWCLO    5
`define GTC_BIT_DIR      4
`define GTC_BIT_ONESHOT  3
`define GTC_BIT_SRCSEL   2
`define GTC_BIT_RUN      0
// status bits: 0 overflow, 1..4 channel events
`define GTC_STAT_W       5
`define GTC_RESET_16     16'h0000
`define GTC_RESET_32     32'h00000000
`endif

/* verilog/gtc_sample_div.v */
`timescale 1ns/10ps
`default_nettype none
// ***********************************
// filter sample clock enable
// ***********************************
module gtc_sample_div
(
    input  wire       clock,
    input  wire       rst,
    input  wire [1:0] divSel,
    output reg        sampleTick
);
    reg [1:0] cnt;
    // divide by 1, 2 or 4; code 11 behaves as no division
    always @(posedge clock)
    begin
        if (rst)
        begin
            cnt        <= 2'h0;
            sampleTick <= 1'b0;
        end
        else
        begin
            cnt <= cnt + 2'h1;
            case (divSel)
                2'h1:    sampleTick <= cnt[0];
                2'h2:    sampleTick <= (cnt == 2'h3);
                default: sampleTick <= 1'b1;
            endcase
        end
    end
endmodule
`default_nettype wire

/* verilog/gtc_compare.v */
`timescale 1ns/10ps
`default_nettype none
// ***********************************
// one compare channel
// ***********************************
module gtc_compare
(
    input  wire        clock,
    input  wire        rst,
    input  wire [31:0] count,
    input  wire [31:0] compare,
    input  wire        running,
    input  wire        flagAllow,
    output reg         hit
);
    // pulse when the counter meets the compare value
    always @(posedge clock)
    begin
        if (rst)
            hit <= 1'b0;
        else
            hit <= running && flagAllow && (count == compare);
    end
endmodule
`default_nettype wire

/* verilog/gtc_timer.v */
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "gtc_regs.vh"
module gtc_timer
#(
    parameter WIDE_INSTANCE = 1
)
(
    input  wire        clock,
    input  wire        rst,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        slaveOverflowEvent,
    output reg         overflowEvent,
    output reg         overflowDmaRequest,
    output reg         sampleTickOut,
    output reg         irq
);
    localparam ST_IDLE = 2'b01;
    localparam ST_RESP = 2'b10;

    reg [15:0] ctrl1;
    reg [31:0] counter;
    reg [31:0] periodActive;
    reg [31:0] periodShadow;
    reg [31:0] cmp [0:3];
    reg [15:0] dmaCtrl;
    reg [15:0] dmaData;
    reg [`GTC_STAT_W-1:0] status;
    reg [`GTC_STAT_W-1:0] mask;
    reg        countDown;
    reg [1:0]  wState;
    reg        awHeld;
    reg        wHeld;
    reg [7:0]  awAddr;
    reg [31:0] wData;
    reg        swTrigger;

    wire [3:0] hit;
    wire       sampleTick;
    integer    i;

    // ***********************************
    // control field decode
    // ***********************************
    wire        plusOn   = (WIDE_INSTANCE != 0) && ctrl1[`GTC_BIT_PLUS];
    wire [31:0] valMask  = plusOn ? 32'hFFFFFFFF : 32'h0000FFFF;
    wire [1:0]  twc      = {ctrl1[`GTC_BIT_TWCHI], ctrl1[`GTC_BIT_TWCLO]};
    wire        running  = ctrl1[`GTC_BIT_RUN];
    wire        goingDown = (twc == 2'h0) ? ctrl1[`GTC_BIT_DIR] : countDown;
    wire [31:0] top      = periodActive & valMask;
    wire [31:0] cnt      = counter & valMask;
    // overflow at period (up) or at zero (down)
    wire        hwOverflow = running && (goingDown ? (cnt == 32'h0) : (cnt == top));
    // event sources chosen by the source select bit
    wire        srcOverflow = hwOverflow ||
                    (!ctrl1[`GTC_BIT_SRCSEL] && (swTrigger || slaveOverflowEvent));
    // channel flags gated by direction in two-way modes 1 and 2; mode 3 flags both ways
    wire        flagAllow = (twc == 2'h0) || (twc == 2'h3) ||
                    (twc == 2'h1 && goingDown) ||
                    (twc == 2'h2 && !goingDown);

    wire        wrFire = (wState == ST_IDLE) && awHeld && wHeld;

    gtc_sample_div u_div
    (
        .clock      (clock),
        .rst        (rst),
        .divSel     ({ctrl1[`GTC_BIT_DIVHI], ctrl1[`GTC_BIT_DIVLO]}),
        .sampleTick (sampleTick)
    );

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : chan
            gtc_compare u_cmp
            (
                .clock     (clock),
                .rst       (rst),
                .count     (cnt),
                .compare   (cmp[g] & valMask),
                .running   (running),
                .flagAllow (flagAllow),
                .hit       (hit[g])
            );
        end
    endgenerate

    // ***********************************
    // axi write channel
    // ***********************************
    always @(posedge clock)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddr        <= 8'h00;
            wData         <= 32'h00000000;
            wState        <= ST_IDLE;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld        <= 1'b1;
                awAddr        <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld        <= 1'b1;
                wData        <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            case (wState)
                ST_IDLE:
                begin
                    if (awHeld && wHeld)
                    begin
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= 2'h0;
                        wState       <= ST_RESP;
                    end
                end
                ST_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        s_axi_bvalid  <= 1'b0;
                        awHeld        <= 1'b0;
                        wHeld         <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready  <= 1'b1;
                        wState        <= ST_IDLE;
                    end
                end
                default: wState <= ST_IDLE;
            endcase
        end
    end

    // ***********************************
    // register writes and counter
    // ***********************************
    always @(posedge clock)
    begin
        if (rst)
        begin
            ctrl1        <= `GTC_RESET_16;
            counter      <= `GTC_RESET_32;
            periodActive <= `GTC_RESET_32;
            periodShadow <= `GTC_RESET_32;
            dmaCtrl      <= `GTC_RESET_16;
            dmaData      <= `GTC_RESET_16;
            mask         <= {`GTC_STAT_W{1'b0}};
            countDown    <= 1'b0;
            swTrigger    <= 1'b0;
            for (i = 0; i < 4; i = i + 1)
                cmp[i] <= `GTC_RESET_32;
        end
        else
        begin
            swTrigger <= 1'b0;
            // counting, direction turn and update handling
            if (running)
            begin
                if (srcOverflow)
                begin
                    if (ctrl1[`GTC_BIT_SHADOW])
                        periodActive <= periodShadow;
                    if (ctrl1[`GTC_BIT_ONESHOT])
                        ctrl1[`GTC_BIT_RUN] <= 1'b0;
                end
                if (twc != 2'h0 && hwOverflow)
                    countDown <= !countDown;
                if (twc != 2'h0 && hwOverflow)
                    counter <= goingDown ? cnt + 32'h1 : cnt - 32'h1; // turn at the end point
                else if (srcOverflow)
                    counter <= goingDown ? top : 32'h0;
                else
                    counter <= goingDown ? cnt - 32'h1 : cnt + 32'h1;
            end
            if (wrFire)
            begin
                case (awAddr)
                    `GTC_OFF_CNTCTL:
                        ctrl1 <= wData[15:0] & `GTC_CNTCTL_MASK;
                    `GTC_OFF_SWTRIG:
                        swTrigger <= wData[0];
                    `GTC_OFF_MASK:
                        mask <= wData[`GTC_STAT_W-1:0];
                    `GTC_OFF_COUNT:
                        counter <= wData & valMask;
                    `GTC_OFF_PERIOD:
                    begin
                        periodShadow <= wData & valMask;
                        if (!ctrl1[`GTC_BIT_SHADOW])
                            periodActive <= wData & valMask;
                    end
                    `GTC_OFF_DMABURST:
                        dmaCtrl <= wData[15:0];
                    `GTC_OFF_DMADATA:
                        dmaData <= wData[15:0];
                    default:
                    begin
                        if (awAddr >= `GTC_OFF_CMP1 && awAddr <= `GTC_OFF_CMP4
                            && awAddr[1:0] == 2'h0)
                            cmp[awAddr[3:2] - 2'h1] <= wData & valMask;
                    end
                endcase
            end
        end
    end

    // ***********************************
    // sticky status, set beats clear
    // ***********************************
    wire [`GTC_STAT_W-1:0] setBits = {hit, srcOverflow};
    wire [`GTC_STAT_W-1:0] clrBits =
        (wrFire && awAddr == `GTC_OFF_STATUS) ? wData[`GTC_STAT_W-1:0] : {`GTC_STAT_W{1'b0}};
    always @(posedge clock)
    begin
        if (rst)
        begin
            status             <= {`GTC_STAT_W{1'b0}};
            irq                <= 1'b0;
            overflowEvent      <= 1'b0;
            overflowDmaRequest <= 1'b0;
            sampleTickOut      <= 1'b0;
        end
        else
        begin
            status             <= (status & ~clrBits) | setBits;
            irq                <= |(((status & ~clrBits) | setBits) & mask);
            overflowEvent      <= srcOverflow;
            overflowDmaRequest <= srcOverflow;
            sampleTickOut      <= sampleTick;
        end
    end

    // ***********************************
    // axi read channel
    // ***********************************
    always @(posedge clock)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
        else if (s_axi_arvalid)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'h0;
            case (s_axi_araddr)
                `GTC_OFF_CNTCTL:   s_axi_rdata <= {16'h0000, ctrl1};
                `GTC_OFF_MASK:     s_axi_rdata <= {27'h0, mask};
                `GTC_OFF_STATUS:   s_axi_rdata <= {27'h0, status};
                `GTC_OFF_SWTRIG:   s_axi_rdata <= 32'h00000000;
                `GTC_OFF_COUNT:    s_axi_rdata <= cnt;
                `GTC_OFF_PERIOD:   s_axi_rdata <= periodShadow;
                `GTC_OFF_DMABURST: s_axi_rdata <= {16'h0000, dmaCtrl};
                `GTC_OFF_DMADATA:  s_axi_rdata <= {16'h0000, dmaData};
                default:
                begin
                    if (s_axi_araddr >= `GTC_OFF_CMP1 && s_axi_araddr <= `GTC_OFF_CMP4
                        && s_axi_araddr[1:0] == 2'h0)
                        s_axi_rdata <= cmp[s_axi_araddr[3:2] - 2'h1];
                    else
                    begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'h2;   // unmapped: slverr
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* sim/gtc_timer_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module gtc_timer_monitor
(
    input wire        clock,
    input wire        rst,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        overflowEvent,
    input wire        overflowDmaRequest,
    input wire        sampleTickOut
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ***********************************
    // bus handshakes
    // ***********************************
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_WR_ANSWER: assert property (wrTaken |-> ##[2:4] s_axi_bvalid)
        else $error("write response missing");
    AST_B_OKAY: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
        else $error("write response not okay");
    AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_R_ANSWER: assert property (rdTaken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    AST_R_ERR: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    // ***********************************
    // event outputs
    // ***********************************
    AST_DMA_PAIR: assert property (overflowEvent == overflowDmaRequest)
        else $error("dma request apart from overflow");
    AST_OVF_PULSE: assert property (overflowEvent |=> !overflowEvent)
        else $error("overflow pulse too long");
    AST_TICK: assert property (sampleTickOut |-> ##[1:4] sampleTickOut)
        else $error("sample tick gap above four");
endmodule
bind gtc_timer gtc_timer_monitor gtc_timer_monitor_i (.clock, .rst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .overflowEvent, .overflowDmaRequest, .sampleTickOut);
`default_nettype wire

/* sim/test_gp_timer_count_control.sv */
`timescale 1ns/10ps
`default_nettype none
`include "gtc_regs.vh"
module test_gp_timer_count_control;
    logic        clock, rst, awValid, wValid, bReady, arValid, rReady, slvEvt;
    logic [7:0]  awAddr, arAddr;
    logic [31:0] wData, rData, rd, v;
    logic [1:0]  bResp, rResp, rr;
    logic        awReady, wReady, bValid, arReady, rValid, ovf, dma, tick, irq;
    int          n_mismatch, compares, nOvf, k, n, o;
    logic [7:0]  offs [6] = '{8'h00, 8'h2C, 8'h24, 8'h40, 8'h48, 8'h4C};
    logic [31:0] md [5] = '{32'h01, 32'h11, 32'h21, 32'h41, 32'h61};
    gtc_timer gtc_timer_i (.clock(clock), .rst(rst),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .slaveOverflowEvent(slvEvt),
        .overflowEvent(ovf), .overflowDmaRequest(dma), .sampleTickOut(tick), .irq(irq));
    // ***********************************
    // clock, event count, watchdog
    // ***********************************
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) if (ovf === 1'b1) nOvf <= nOvf + 1;
    initial
    begin
        #300000;
        n_mismatch++;
        conclude();
    end
    // ***********************************
    // expectations, bus cycles, compare
    // ***********************************
    function automatic logic [31:0] wmask(input int pm, input logic [31:0] d);
        return pm ? d : {16'h0000, d[15:0]};
    endfunction
    function automatic int ticks(input int dv);
        return dv == 1 ? 8 : dv == 2 ? 4 : 16;
    endfunction
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        // ready stays up between calls; only the watchdog ends a wait
        do
        begin
            @(posedge clock);
            if (awValid && awReady === 1'b1)
                awValid <= 1'b0;
            if (wValid && wReady === 1'b1)
                wValid <= 1'b0;
        end
        while (bValid !== 1'b1);
    endtask
    task automatic axr(input logic [7:0] a);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do
        begin
            @(posedge clock);
            if (arValid && arReady === 1'b1)
                arValid <= 1'b0;
        end
        while (rValid !== 1'b1);
        rd = rData;
        rr = rResp;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chkIrq(input logic e);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, {31'h0, e});
    endtask
    task automatic conclude();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ***********************************
    // test sequence
    // ***********************************
    initial
    begin
        {awValid, wValid, bReady, arValid, rReady, slvEvt} = 6'h00;
        {awAddr, arAddr, wData} = 48'h0;
        {rst, n_mismatch, compares, nOvf} = {1'b1, 96'h0};
        void'($urandom(64284));
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        // reset values and an unmapped read
        for (k = 0; k < 6; k++)
        begin
            axr(offs[k]);
            chk(rd, 32'h0);
        end
        axr(8'h80);
        chk({30'h0, rr}, 32'h2);
        chk(rd, 32'h0);
        $display("test 1 done");
        // period, count and compare 4 register width with plus width off and on
        for (k = 0; k < 2; k++)
        begin
            axw(`GTC_OFF_CNTCTL, k << 10);
            for (n = 0; n < 3; n++)
            begin
                v = $urandom | 32'h80000000;
                axw(offs[n + 1], v);
                axr(offs[n + 1]);
                chk(rd, wmask(k, v));
            end
        end
        $display("test 2 done");
        // control fields other than run read back, reserved bits written as zero
        for (k = 0; k < 4; k++)
        begin
            v = k == 0 ? 32'h7FC : $urandom & 32'h7FC;
            axw(`GTC_OFF_CNTCTL, v);
            axr(`GTC_OFF_CNTCTL);
            chk(rd, v);
        end
        $display("test 3 done");
        // sample tick rate per divider code
        for (k = 0; k < 4; k++)
        begin
            axw(`GTC_OFF_CNTCTL, k << 8);
            repeat (4) @(posedge clock);
            n = 0;
            repeat (16)
            begin
                @(posedge clock);
                n += tick;
            end
            chk(32'(n), 32'(ticks(k)));
        end
        $display("test 4 done");
        // software and slave events per source select
        axw(`GTC_OFF_MASK, 32'h1);
        for (k = 0; k < 2; k++)
        begin
            axw(`GTC_OFF_CNTCTL, k << 2);
            axw(`GTC_OFF_STATUS, 32'h1F);
            o = nOvf;
            axw(`GTC_OFF_SWTRIG, 32'h1);
            repeat ($urandom_range(3, 6)) @(posedge clock);
            slvEvt <= 1'b1;
            @(posedge clock);
            slvEvt <= 1'b0;
            repeat (3) @(posedge clock);
            chk(32'(nOvf - o), k ? 32'h0 : 32'h2);
            axr(`GTC_OFF_STATUS);
            chk(rd & 32'h1, k ? 32'h0 : 32'h1);
            chkIrq(!k);
            if (k == 0)
            begin
                axw(`GTC_OFF_MASK, 32'h0);
                chkIrq(0);
                axw(`GTC_OFF_MASK, 32'h1);
                chkIrq(1);
            end
        end
        $display("test 5 done");
        // single shot, buffered period, counting modes, halt
        axw(`GTC_OFF_PERIOD, 32'h6);
        axw(`GTC_OFF_COUNT, 32'h0);
        o = nOvf;
        axw(`GTC_OFF_CNTCTL, 32'h9);
        repeat (40) @(posedge clock);
        chk(32'(nOvf - o), 32'h1);
        axr(`GTC_OFF_CNTCTL);
        chk(rd, 32'h8);
        axw(`GTC_OFF_CNTCTL, 32'h80);
        axw(`GTC_OFF_PERIOD, 32'h3);
        axw(`GTC_OFF_COUNT, 32'h5);
        o = nOvf;
        axw(`GTC_OFF_CNTCTL, 32'h89);
        repeat (40) @(posedge clock);
        chk(32'(nOvf - o), 32'h1);
        for (k = 0; k < 5; k++)
        begin
            axw(`GTC_OFF_CNTCTL, md[k]);
            o = nOvf;
            repeat (60) @(posedge clock);
            chk(32'(nOvf - o > 4), 32'h1);
        end
        axw(`GTC_OFF_CNTCTL, 32'h0);
        axr(`GTC_OFF_COUNT);
        v = rd;
        o = nOvf;
        repeat (20) @(posedge clock);
        axr(`GTC_OFF_COUNT);
        chk(rd, v);
        chk(32'(nOvf - o), 32'h0);
        $display("test 6 done");
        conclude();
    end
endmodule
`default_nettype wire
